// File: core/hbdiag_decode.v
// Per-driver flag gating and result decode for the load diagnostic.
// Assumes the comparator level is synchronous to hclk.
`include "hbdiag_defs.vh"
module hbdiag_decode (
    // Enables and configuration
    input wire high_on,
    input wire low_on,
    input wire other_low_on,
    input wire [1:0] load_cfg,
    // Live comparator level
    input wire level,
    // Results
    output wire flag,
    output reg [1:0] verdict
);
    // Codes: 0 normal, 1 short, 2 open, 3 invalid or disabled
    assign flag = (high_on | low_on) & level;

    always @* begin
        verdict = 2'h3;
        if (high_on ^ low_on) begin
            case (load_cfg)
                // A high source on a ground load cannot tell open from short; both read short
                `HBD_LOAD_GND: verdict = flag ? 2'h1 : 2'h0;
                `HBD_LOAD_SUP: verdict = flag ? 2'h0 : 2'h1;
                `HBD_LOAD_BRIDGE: verdict = (other_low_on & !flag) ? 2'h0 : 2'h2;
                default: verdict = 2'h3;
            endcase
        end
    end
endmodule // hbdiag_decode

// File: core/hbdiag_top.v
// Half-bridge load diagnostic control with AHB-Lite register slave.
// Assumes hclk at 10 MHz and all pin inputs synchronous to hclk.
`include "hbdiag_defs.vh"
module hbdiag_top #(
    parameter N = `HBD_DRIVERS
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Analog side
    input wire over_temp,
    input wire [N-1:0] out_level,
    input wire [N-1:0] other_bridge_low_on,
    output reg [N-1:0] high_source_on,
    output reg [N-1:0] low_sink_on,
    output reg [N-1:0] oc_suppress,
    output reg [N-1:0] open_short_flag,
    // Interrupt
    output reg irq
);
    reg [7:0] diag_source_enable;
    reg [7:0] load_cfg;
    reg [7:0] irq_stat;
    reg [7:0] irq_mask;
    reg [N-1:0] flag_q;
    reg ovt_q;
    reg wr_pend;
    reg rd_pend;
    reg [5:0] addr_q;
    wire [N-1:0] flag_live;
    wire [2*N-1:0] verdict;
    wire access;
    reg [7:0] next_irq_stat;
    reg [31:0] next_rdata;

    assign access = hsel & hready & (htrans == `HBD_HTRANS_NONSEQ || htrans == `HBD_HTRANS_SEQ);

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_drv
            hbdiag_decode u_dec (
                .high_on(diag_source_enable[2*i+1]),
                .low_on(diag_source_enable[2*i]),
                .other_low_on(other_bridge_low_on[i]),
                .load_cfg(load_cfg[2*i+1:2*i]),
                .level(out_level[i]),
                .flag(flag_live[i]),
                .verdict(verdict[2*i+1:2*i])
            );
        end
    endgenerate

    // Bus: zero wait state, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 6'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= access & hwrite;
            rd_pend <= access & !hwrite;
            if (access) begin
                addr_q <= haddr[7:2];
            end
            hrdata <= next_rdata;
        end
    end

    // Read data formed in address phase so it stands in the data phase
    always @* begin
        next_rdata = 32'h0000_0000;
        if (access & !hwrite) begin
            case (haddr[7:2])
                `HBD_IDX_DIAG: next_rdata = {24'h000000, diag_source_enable};
                `HBD_IDX_STAT: next_rdata = {24'h000000, flag_live, 4'h0};
                `HBD_IDX_IRQ_STAT: next_rdata = {24'h000000, irq_stat};
                `HBD_IDX_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
                `HBD_IDX_CFG: next_rdata = {16'h0000, verdict, load_cfg};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Control registers; over-temperature wins over a write to diag_source_enable
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diag_source_enable <= `HBD_DIAG_RESET;
            load_cfg <= 8'h00;
            irq_mask <= 8'h00;
        end else begin
            if (wr_pend && addr_q == `HBD_IDX_DIAG) begin
                diag_source_enable <= hwdata[7:0];
            end
            if (wr_pend && addr_q == `HBD_IDX_CFG) begin
                load_cfg <= hwdata[7:0];
            end
            if (wr_pend && addr_q == `HBD_IDX_IRQ_MASK) begin
                irq_mask <= hwdata[7:0];
            end
            if (over_temp) begin
                diag_source_enable <= 8'h00;
            end
        end
    end

    // Events: over-temperature and rising open/short flags; read clears, set wins
    always @* begin
        next_irq_stat = irq_stat;
        // Clear only what the read returned, so an event in the address phase survives
        if (rd_pend && addr_q == `HBD_IDX_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~hrdata[7:0];
        end
        if (over_temp & !ovt_q) begin
            next_irq_stat[`HBD_IRQ_OVT] = 1'b1;
        end
        next_irq_stat[`HBD_IRQ_FLAG_LO +: N] = next_irq_stat[`HBD_IRQ_FLAG_LO +: N]
            | (flag_live & ~flag_q);
    end

    // Outputs registered; sources also gated by live over-temperature
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 8'h00;
            flag_q <= {N{1'b0}};
            ovt_q <= 1'b0;
            high_source_on <= {N{1'b0}};
            low_sink_on <= {N{1'b0}};
            oc_suppress <= {N{1'b0}};
            open_short_flag <= {N{1'b0}};
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            flag_q <= flag_live;
            ovt_q <= over_temp;
            high_source_on <= over_temp ? {N{1'b0}} : hi_bits(diag_source_enable);
            low_sink_on <= over_temp ? {N{1'b0}} : lo_bits(diag_source_enable);
            // Suppression follows enables, not the gated sources, to stay safe
            oc_suppress <= hi_bits(diag_source_enable) | lo_bits(diag_source_enable);
            open_short_flag <= flag_live;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    function [N-1:0] hi_bits;
        input [7:0] v;
        integer k;
        begin
            for (k = 0; k < N; k = k + 1) hi_bits[k] = v[2*k+1];
        end
    endfunction

    function [N-1:0] lo_bits;
        input [7:0] v;
        integer k;
        begin
            for (k = 0; k < N; k = k + 1) lo_bits[k] = v[2*k];
        end
    endfunction
endmodule // hbdiag_top

// File: shared/hbdiag_defs.vh
// Constants for the half-bridge load diagnostic block.
// Assumes an AHB-Lite slave with 32-bit data and one word per register.
`ifndef HBDIAG_DEFS_VH
`define HBDIAG_DEFS_VH

// Register indices (byte address offsets are the index times four)
`define HBD_IDX_DIAG 6'h07
`define HBD_IDX_STAT 6'h0a
`define HBD_IDX_IRQ_STAT 6'h10
`define HBD_IDX_IRQ_MASK 6'h11
`define HBD_IDX_CFG 6'h12
`define HBD_DIAG_RESET 8'h00
`define HBD_DRIVERS 4
`define HBD_HTRANS_NONSEQ 2'h2
`define HBD_HTRANS_SEQ 2'h3

// Interrupt status bits
`define HBD_IRQ_OVT 0
`define HBD_IRQ_FLAG_LO 4
`define HBD_IRQ_WIDTH 8

// Load configuration codes per driver
`define HBD_LOAD_GND 2'h0
`define HBD_LOAD_SUP 2'h1
`define HBD_LOAD_BRIDGE 2'h2

`endif

// File: testbench/half_bridge_load_diagnostic_tb.sv
// Self-checking bench for the load diagnostic block.
// Drives the AHB-Lite slave at 10 MHz; a load model sits on the outputs.
module half_bridge_load_diagnostic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 0, hresetn = 0, hwrite = 0, over_temp = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, r;
    logic [7:0] kind = 8'ha4, d;
    logic [3:0] other_bridge_low_on = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq;
    wire [3:0] out_level, high_source_on, low_sink_on, oc_suppress, open_short_flag;
    int fail_count = 0, checks_done = 0, cyc = 0;
    logic [19:0] rows [5] = '{{8'h55, 8'ha4, 4'h2}, {8'haa, 8'ha4, 4'he},
        {8'h00, 8'ha4, 4'h0}, {8'h96, 8'ha4, 4'ha}, {8'h96, 8'h24, 4'h2}};
    hbdiag_top hbdiag_top_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .over_temp,
        .out_level, .other_bridge_low_on, .high_source_on, .low_sink_on, .oc_suppress,
        .open_short_flag, .irq);
    hbd_load_model hbd_load_model_i (.hclk, .high_source_on, .low_sink_on,
        .load_kind(kind), .out_level);
    initial begin
        forever #50 hclk = ~hclk;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (!hreadyout);
        r = hrdata;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(8'h1c, 0, 0);
        chk(r, 0);
        xfer(8'h3c, 1, 32'hff);
        xfer(8'h3c, 0, 0);
        chk(r, 0);
        foreach (rows[k]) begin
            d = rows[k][19:12];
            kind <= rows[k][11:4];
            xfer(8'h1c, 1, {24'h0, d});
            repeat (4) @(posedge hclk);
            chk(open_short_flag, rows[k][3:0]);
            chk(high_source_on, {d[7], d[5], d[3], d[1]});
            chk(low_sink_on, {d[6], d[4], d[2], d[0]});
            chk(oc_suppress, {d[7] | d[6], d[5] | d[4], d[3] | d[2], d[1] | d[0]});
            xfer(8'h28, 0, 0);
            chk(r, {rows[k][3:0], 4'h0});
            xfer(8'h1c, 0, 0);
            chk(r, d);
        end
        // Last row left drivers 0,1,3 on ground, supply, ground and driver 2 open
        xfer(8'h48, 1, 32'h24);
        xfer(8'h48, 0, 0);
        chk(r, 32'h0000_2024);
        other_bridge_low_on <= 4'h4;
        xfer(8'h48, 0, 0);
        chk(r, 32'h0000_0024);
        other_bridge_low_on <= 4'h0;
        xfer(8'h44, 1, 1);
        xfer(8'h40, 0, 0);
        chk(r, 32'h0000_00e0);
        over_temp <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({high_source_on, low_sink_on, oc_suppress}, 0);
        chk(irq, 1);
        xfer(8'h40, 0, 0);
        chk(r[0], 1);
        // Overtemp outranks a write landing meanwhile
        xfer(8'h1c, 1, 32'hff);
        xfer(8'h1c, 0, 0);
        chk(r, 0);
        chk(irq, 0);
        over_temp <= 1'b0;
        xfer(8'h44, 1, 0);
        over_temp <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(irq, 0);
        over_temp <= 1'b0;
        // Reset in mid-run with sources on must drop everything at once
        xfer(8'h1c, 1, 32'h55);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({high_source_on, low_sink_on, oc_suppress, open_short_flag}, 0);
        chk({irq, hreadyout, hresp}, 3'h2);
        hresetn <= 1'b1;
        xfer(8'h1c, 0, 0);
        chk(r, 0);
        xfer(8'h48, 0, 0);
        chk(r, 32'h0000_ff00);
        xfer(8'h1c, 1, 0);
        end_sim();
    end
endmodule // half_bridge_load_diagnostic_tb

// File: testbench/hbd_checker.sv
// Port assertions for the load diagnostic block.
// Bound into hbdiag_top; one clock, hresetn active low.
module hbd_checker #(parameter N = 4) (
    input wire hclk, input wire hresetn, input wire hsel, input wire hready,
    input wire [31:0] haddr, input wire [1:0] htrans, input wire hwrite,
    input wire [31:0] hwdata, input wire [31:0] hrdata, input wire hreadyout,
    input wire hresp, input wire over_temp, input wire irq, input wire [N-1:0] out_level,
    input wire [N-1:0] high_source_on, input wire [N-1:0] low_sink_on,
    input wire [N-1:0] oc_suppress, input wire [N-1:0] open_short_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_wr;
        logic [7:0] d;
        hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h1c ##1
        (!over_temp, d = hwdata[7:0]) ##1 !over_temp |=>
        {high_source_on, low_sink_on} == {d[7], d[5], d[3], d[1], d[6], d[4], d[2], d[0]};
    endproperty
    a_wr_lat: assert property (p_wr) else $error("sources differ from write");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
    a_ot_off: assert property (over_temp |=> !(high_source_on | low_sink_on))
        else $error("source on in overtemp");
    a_ot_clears: assert property (over_temp [*2] |=> oc_suppress == 0)
        else $error("enables kept in overtemp");
    a_supp_cover: assert property (((high_source_on | low_sink_on) & ~oc_suppress) == 0)
        else $error("source on unsuppressed");
    a_flag_live: assert property ((open_short_flag & ~$past(out_level)) == 0)
        else $error("flag without level");
    a_flag_off: assert property ((open_short_flag & ~(oc_suppress | $past(oc_suppress))) == 0)
        else $error("flag with diag off");
    a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 0)
        else $error("stray read data");
    c_ot: cover property ($rose(over_temp));
    c_flag: cover property (|open_short_flag);
    c_irq: cover property ($rose(irq));
endmodule // hbd_checker
bind hbdiag_top hbd_checker #(.N(N)) hbd_checker_i (.*);

// File: testbench/hbd_load_model.sv
// Load on the four driver outputs: kind 0 pulls low, 1 pulls high, 2 open.
// Assumes sources come from hbdiag_top and the kind from the bench.
module hbd_load_model (
    input wire hclk,
    input wire [3:0] high_source_on, input wire [3:0] low_sink_on, input wire [7:0] load_kind,
    output logic [3:0] out_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wob = 1'b0;
    // An unfed open pin toggles so no stale level can pass
    always @(posedge hclk) wob <= ~wob;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (load_kind[2*i+:2])
                2'h0: out_level[i] = 1'b0;
                2'h1: out_level[i] = 1'b1;
                default: out_level[i] = high_source_on[i] ? 1'b1 : (low_sink_on[i] ? 1'b0 : wob);
            endcase
        end
    end
endmodule // hbd_load_model
